// >>> rtl/increment_skip_if_zero.sv
// executor for the increment register, skip if zero instruction
//
// Summary of operation
// - match 0011 11da ffff ffff, add one
// - dest bit one writes result to register
// - write-back to register is default destination
// - zero result discards already fetched instruction
// - idle slot replaces it; two cycles
// - skip over two-word instruction takes three
// - bank bit zero uses shared access bank
// - bank bit one uses bank selector
// - extended set, bank zero, f<=95: indexed
// - dest bit zero writes accumulator only
`timescale 1ns/10ps
`default_nettype none
module increment_skip_if_zero (
  input wire logic clock_in,                              // 125 MHz clock
  input wire logic rst_in,                                // sync reset, high
  input wire logic instr_valid_in,                        // word offered
  input wire logic [15:0] instr_in,                       // instruction word
  input wire logic next_two_word_in,                      // next is 2 words
  input wire logic ext_set_in,                            // extended set on
  input wire logic [incsz_pkg::BSEL_W-1:0] bank_sel_in,   // bank selector
  input wire logic [incsz_pkg::ADDR_W-1:0] index_base_in, // index pointer
  input wire logic [incsz_pkg::DATA_W-1:0] rd_data_in,    // file read data
  output logic ready_out,                                 // may take word
  output logic [incsz_pkg::ADDR_W-1:0] addr_out,          // file address
  output logic rd_en_out,                                 // file read
  output logic wr_en_out,                                 // file write
  output logic [incsz_pkg::DATA_W-1:0] wr_data_out,       // file write data
  output logic [incsz_pkg::DATA_W-1:0] accum_out,         // accumulator
  output logic flush_out,                                 // discard fetched
  output logic idle_slot_out,                             // idle slot runs
  output logic status_we_out,                             // flag update
  output logic done_out                                   // instr finished
);
  import incsz_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  exec_state_t state, next_state;
  logic [1:0] quarter, next_quarter;
  logic dest, next_dest;
  logic two_word, next_two_word;
  logic [DATA_W-1:0] data, next_data;
  logic [ADDR_W-1:0] next_addr;
  logic next_ready, next_rd_en, next_wr_en, next_flush, next_idle_slot;
  logic next_done;
  logic [DATA_W-1:0] next_wr_data, next_accum;
  logic opc_match;
  logic [7:0] fadr;
  logic [ADDR_W-1:0] eff_addr;

  assign opc_match = instr_valid_in &&
                     (instr_in[OPC_MSB:OPC_LSB] == OPC_UPPER);
  assign fadr = instr_in[7:0];

  // ---------------------------------------------------------------
  // address resolution
  // ---------------------------------------------------------------
  always_comb begin
    if (instr_in[BANK_BIT]) begin
      eff_addr = {bank_sel_in, fadr};
    end else if (ext_set_in && fadr <= INDEX_LIMIT) begin
      eff_addr = index_base_in + {4'h0, fadr};
    end else if (fadr < ACCESS_SPLIT) begin
      eff_addr = {4'h0, fadr};
    end else begin
      eff_addr = {ACCESS_HI_BANK, fadr};
    end
  end

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_quarter = quarter + 2'h1;
    next_dest = dest;
    next_two_word = two_word;
    next_data = data;
    next_addr = addr_out;
    next_rd_en = 1'b0;
    next_wr_en = 1'b0;
    next_wr_data = wr_data_out;
    next_accum = accum_out;
    next_flush = 1'b0;
    next_idle_slot = 1'b0;
    next_done = 1'b0;
    next_ready = 1'b0;
    unique case (state)
      ST_IDLE: begin
        next_quarter = FIRST_QUARTER;
        next_ready = 1'b1;
        if (opc_match && ready_out) begin
          // first quarter: decode and address
          next_state = ST_EXEC;
          next_quarter = 2'h1;
          next_ready = 1'b0;
          next_dest = instr_in[DEST_BIT];
          next_two_word = next_two_word_in;
          next_addr = eff_addr;
          next_rd_en = 1'b1;
        end
      end
      ST_EXEC: begin
        unique case (quarter)
          2'h1: next_data = rd_data_in;
          2'h2: next_data = data + ONE_BYTE;
          2'h3: begin
            next_wr_en = dest;
            next_wr_data = data;
            if (!dest) begin
              next_accum = data;
            end
            if (data == ZERO_BYTE) begin
              next_state = ST_SLOT;
              next_flush = 1'b1;
              next_idle_slot = 1'b1;
            end else begin
              next_state = ST_IDLE;
              next_done = 1'b1;
              next_ready = 1'b1;
            end
          end
          default: next_state = ST_IDLE;
        endcase
      end
      ST_SLOT, ST_SLOT2: begin
        next_idle_slot = 1'b1;
        if (quarter == LAST_QUARTER) begin
          if (state == ST_SLOT && two_word) begin
            next_state = ST_SLOT2;
          end else begin
            next_state = ST_IDLE;
            next_idle_slot = 1'b0;
            next_done = 1'b1;
            next_ready = 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state <= ST_IDLE;
      quarter <= FIRST_QUARTER;
      dest <= 1'b1;
      two_word <= 1'b0;
      data <= ZERO_BYTE;
      addr_out <= '0;
      rd_en_out <= 1'b0;
      wr_en_out <= 1'b0;
      wr_data_out <= ZERO_BYTE;
      accum_out <= ZERO_BYTE;
      flush_out <= 1'b0;
      idle_slot_out <= 1'b0;
      done_out <= 1'b0;
      ready_out <= 1'b0;
      status_we_out <= 1'b0;
    end else begin
      state <= next_state;
      quarter <= next_quarter;
      dest <= next_dest;
      two_word <= next_two_word;
      data <= next_data;
      addr_out <= next_addr;
      rd_en_out <= next_rd_en;
      wr_en_out <= next_wr_en;
      wr_data_out <= next_wr_data;
      accum_out <= next_accum;
      flush_out <= next_flush;
      idle_slot_out <= next_idle_slot;
      done_out <= next_done;
      ready_out <= next_ready;
      status_we_out <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  logic take;
  assign take = opc_match && ready_out;

  AST_MATCH_READ: assert property (
    @(posedge clock_in) disable iff (rst_in)
    take |=> rd_en_out && addr_out == $past(eff_addr))
    else $error("matched opcode did not start a read");

  AST_INCREMENT: assert property (
    @(posedge clock_in) disable iff (rst_in)
    take ##1 rd_en_out |-> ##3
      wr_data_out == $past(rd_data_in, 3) + ONE_BYTE)
    else $error("result is not read value plus one");

  AST_DEST_REG: assert property (
    @(posedge clock_in) disable iff (rst_in)
    take && instr_in[DEST_BIT] |=> ##3 wr_en_out && $stable(accum_out))
    else $error("register destination not written");

  AST_DEST_ACC: assert property (
    @(posedge clock_in) disable iff (rst_in)
    take && !instr_in[DEST_BIT] |=> !wr_en_out [*4] ##0
      accum_out == wr_data_out)
    else $error("accumulator destination misbehaved");

  AST_SKIP: assert property (
    @(posedge clock_in) disable iff (rst_in)
    wr_data_out == ZERO_BYTE && $rose(wr_en_out | flush_out) && flush_out
      |-> idle_slot_out ##1 !flush_out)
    else $error("flush without idle slot");

  AST_FLUSH_ZERO: assert property (
    @(posedge clock_in) disable iff (rst_in)
    flush_out |-> wr_data_out == ZERO_BYTE)
    else $error("flush on nonzero result");

  AST_TWO_CYCLE: assert property (
    @(posedge clock_in) disable iff (rst_in)
    take && !next_two_word_in ##4 flush_out |-> ##4 done_out)
    else $error("skip did not take two cycles");

  AST_THREE_CYCLE: assert property (
    @(posedge clock_in) disable iff (rst_in)
    take && next_two_word_in ##4 flush_out
      |-> (idle_slot_out && !done_out) [*8] ##1 done_out)
    else $error("two-word skip not three cycles");

  AST_NO_SKIP: assert property (
    @(posedge clock_in) disable iff (rst_in)
    wr_en_out && wr_data_out != ZERO_BYTE |-> done_out && !flush_out)
    else $error("nonzero result did not finish in one cycle");

  AST_ACCESS: assert property (
    @(posedge clock_in) disable iff (rst_in)
    take && !instr_in[BANK_BIT] && !ext_set_in
      |=> addr_out[11:8] == 4'h0 || addr_out[11:8] == ACCESS_HI_BANK)
    else $error("access bank address wrong");

  AST_BANKED: assert property (
    @(posedge clock_in) disable iff (rst_in)
    take && instr_in[BANK_BIT] |=> addr_out[11:8] == $past(bank_sel_in))
    else $error("bank selector not used");

  AST_INDEXED: assert property (
    @(posedge clock_in) disable iff (rst_in)
    take && !instr_in[BANK_BIT] && ext_set_in && fadr <= INDEX_LIMIT
      |=> addr_out == $past(index_base_in) + {4'h0, $past(fadr)})
    else $error("indexed address wrong");

  AST_FLAGS: assert property (
    @(posedge clock_in) disable iff (rst_in)
    !status_we_out)
    else $error("status flags touched");

  AST_QUARTERS: assert property (
    @(posedge clock_in) disable iff (rst_in)
    take |=> rd_en_out ##1 !rd_en_out ##2 (wr_en_out || $changed(accum_out)
      || accum_out == wr_data_out))
    else $error("quarter order broken");
endmodule : increment_skip_if_zero
`default_nettype wire

// >>> rtl/incsz_pkg.sv
// shared constants for the increment-and-skip-if-zero executor
package incsz_pkg;
  localparam logic [5:0] OPC_UPPER = 6'h0F;  // top six opcode bits 0011 11
  localparam int OPC_MSB = 15;
  localparam int OPC_LSB = 10;
  localparam int DEST_BIT = 9;
  localparam int BANK_BIT = 8;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 12;
  localparam int BSEL_W = 4;
  localparam logic [7:0] INDEX_LIMIT = 8'h5F;   // indexed mode for f <= 95
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;  // lower access half ends here
  localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
  localparam logic [1:0] LAST_QUARTER = 2'h3;
  localparam logic [1:0] FIRST_QUARTER = 2'h0;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] ONE_BYTE = 8'h01;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_EXEC,
    ST_SLOT,
    ST_SLOT2
  } exec_state_t;
endpackage : incsz_pkg

// >>> testbench/tb_top.sv
// self-checking bench for the increment, skip-if-zero executor
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import incsz_pkg::*;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic instr_valid_in = 1'b0;
  logic [15:0] instr_in = 16'h0000;
  logic next_two_word_in = 1'b0;
  logic ext_set_in = 1'b0;
  logic [BSEL_W-1:0] bank_sel_in = 4'h0;
  logic [ADDR_W-1:0] index_base_in = 12'h000;
  logic [DATA_W-1:0] rd_data_in = 8'h00;
  logic ready_out, rd_en_out, wr_en_out, flush_out, idle_slot_out;
  logic status_we_out, done_out;
  logic [ADDR_W-1:0] addr_out;
  logic [DATA_W-1:0] wr_data_out, accum_out;
  int mismatches = 0;
  int total_checks = 0;

  increment_skip_if_zero u_dut (.clock_in(clock_in), .rst_in(rst_in),
    .instr_valid_in(instr_valid_in), .instr_in(instr_in),
    .next_two_word_in(next_two_word_in), .ext_set_in(ext_set_in),
    .bank_sel_in(bank_sel_in), .index_base_in(index_base_in),
    .rd_data_in(rd_data_in), .ready_out(ready_out), .addr_out(addr_out),
    .rd_en_out(rd_en_out), .wr_en_out(wr_en_out),
    .wr_data_out(wr_data_out), .accum_out(accum_out),
    .flush_out(flush_out), .idle_slot_out(idle_slot_out),
    .status_we_out(status_we_out), .done_out(done_out));

  always #4 clock_in = ~clock_in;

  // ----------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------
  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // one instruction: offer word, watch outputs cycle by cycle
  task automatic exec_op(input logic [15:0] w, input logic two,
                         input logic [7:0] v, input logic [11:0] ea);
    logic [7:0] res, acc0, wd;
    logic [15:0] exp_dn, exp_idle;
    int rd_c, wr_c, fl_c, dn_c, idle_n, st_n, n;
    #1;
    res = v + 8'h01;
    exp_dn = (res != 8'h00) ? 16'h0004 : (two ? 16'h000C : 16'h0008);
    exp_idle = (res != 8'h00) ? 16'h0000 : (two ? 16'h0008 : 16'h0004);
    rd_c = 0; wr_c = 0; fl_c = 0; dn_c = 0; idle_n = 0; st_n = 0; n = 0;
    wd = 8'h00;
    while (ready_out !== 1'b1) begin
      n++;
      if (n > 20) begin
        mismatches++;
        wrap_up();
      end
      @(posedge clock_in);
      #1;
    end
    acc0 = accum_out;
    @(posedge clock_in);
    instr_valid_in <= 1'b1;
    instr_in <= w;
    next_two_word_in <= two;
    rd_data_in <= v;
    for (int c = 1; c <= 14 && dn_c == 0; c++) begin
      @(posedge clock_in);
      if (c == 1) instr_valid_in <= 1'b0;
      #1;
      if (rd_en_out === 1'b1) begin
        rd_c = c;
        chk(16'(addr_out), 16'(ea));
      end
      if (wr_en_out === 1'b1) begin
        wr_c = c;
        wd = wr_data_out;
      end
      if (flush_out === 1'b1) fl_c = c;
      if (done_out === 1'b1) dn_c = c;
      if (idle_slot_out === 1'b1) idle_n++;
      if (status_we_out !== 1'b0) st_n++;
    end
    chk(16'(rd_c), 16'h0001);
    chk(16'(dn_c), exp_dn);
    chk(16'(fl_c), res == 8'h00 ? 16'h0004 : 16'h0000);
    chk(16'(idle_n), exp_idle);
    chk(16'(st_n), 16'h0000);
    if (w[DEST_BIT]) begin
      chk(16'(wr_c), 16'h0004);
      chk(16'(wd), 16'(res));
      chk(16'(accum_out), 16'(acc0));
    end else begin
      chk(16'(wr_c), 16'h0000);
      chk(16'(accum_out), 16'(res));
    end
    @(posedge clock_in);
  endtask : exec_op

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_write_back;
    bank_sel_in <= 4'hA;
    exec_op(16'h3F34, 1'b0, 8'h41, 12'hA34);
    $display("test write_back done");
  endtask : t_write_back

  task automatic t_to_accum;
    exec_op(16'h3C20, 1'b0, 8'h7F, 12'h020);
    exec_op(16'h3C80, 1'b0, 8'h00, 12'hF80);
    $display("test to_accum done");
  endtask : t_to_accum

  task automatic t_skip;
    exec_op(16'h3E10, 1'b0, 8'hFF, 12'h010);
    exec_op(16'h3C11, 1'b0, 8'hFF, 12'h011);
    bank_sel_in <= 4'h3;
    exec_op(16'h3F05, 1'b1, 8'hFF, 12'h305);
    $display("test skip done");
  endtask : t_skip

  task automatic t_indexed;
    ext_set_in <= 1'b1;
    index_base_in <= 12'h123;
    exec_op(16'h3E5F, 1'b0, 8'h10, 12'h182);
    exec_op(16'h3E60, 1'b0, 8'h20, 12'hF60);
    bank_sel_in <= 4'h5;
    exec_op(16'h3F20, 1'b0, 8'h30, 12'h520);
    ext_set_in <= 1'b0;
    $display("test indexed done");
  endtask : t_indexed

  task automatic t_refused;
    int rd_n;
    rd_n = 0;
    @(posedge clock_in);
    instr_valid_in <= 1'b1;
    instr_in <= 16'h3B34;
    for (int c = 0; c < 8; c++) begin
      @(posedge clock_in);
      #1;
      if (rd_en_out !== 1'b0) rd_n++;
    end
    chk(16'(rd_n), 16'h0000);
    chk(16'(ready_out), 16'h0001);
    @(posedge clock_in);
    instr_valid_in <= 1'b0;
    $display("test refused done");
  endtask : t_refused

  initial begin
    repeat (20) @(posedge clock_in);
    rst_in <= 1'b0;
    @(posedge clock_in);
    t_write_back();
    t_to_accum();
    t_skip();
    t_indexed();
    t_refused();
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
